//--- include/brw_pkg.sv
`default_nettype none
package brw_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int LEN_W = 16;
  localparam int PITCH_W = 16;
  localparam int DATA_W = 8;
  localparam int REG_AW = 4;
  localparam int REG_DW = 32;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [REG_AW-1:0] OFS_SRC_ADDR = 4'h0;
  localparam logic [REG_AW-1:0] OFS_DST_ADDR = 4'h1;
  localparam logic [REG_AW-1:0] OFS_SRC_PITCH = 4'h2;
  localparam logic [REG_AW-1:0] OFS_DST_PITCH = 4'h3;
  localparam logic [REG_AW-1:0] OFS_GEOM = 4'h4;
  localparam logic [REG_AW-1:0] OFS_CTRL = 4'h5;
  localparam logic [REG_AW-1:0] OFS_IND_PTR = 4'h6;
  localparam logic [REG_AW-1:0] OFS_IND_SIZE = 4'h7;
  localparam logic [REG_AW-1:0] OFS_STATUS = 4'h8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GEOM_LINES_LO = 16;
  localparam int CTL_START = 0;
  localparam int CTL_COORD = 1;
  localparam int CTL_CORNER_LO = 2;
  localparam int CTL_STREAM = 4;
  localparam int CTL_MONO = 5;
  localparam int CTL_INDIRECT = 6;
  localparam int ST_BUSY = 0;
  localparam int ST_CORNER_LO = 1;
  localparam int ST_OVERLAP = 3;
  localparam int ST_DONE = 4;
  localparam int ST_ERR_MONO = 5;
  localparam int ST_ERR_SIZE = 6;

  // ----------------------------------------------------------------
  // Corners: bit 0 starts at the right, bit 1 at the bottom
  // ----------------------------------------------------------------
  localparam int CORNER_XREV = 0;
  localparam int CORNER_YREV = 1;
  localparam logic [1:0] CORNER_UL = 2'h0;
  localparam logic [1:0] CORNER_BR = 2'h3;
  localparam logic [REG_DW-1:0] CTRL_RESET = 32'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_FETCH,
    ST_WRITE
  } brw_state_t;
endpackage
`default_nettype wire

//--- logic/brw_overlap.sv
`default_nettype none
module brw_overlap import brw_pkg::*; (
  input wire logic [ADDR_W-1:0] srcBase,
  input wire logic [ADDR_W-1:0] dstBase,
  input wire logic [PITCH_W-1:0] srcPitch,
  input wire logic [PITCH_W-1:0] dstPitch,
  input wire logic [LEN_W-1:0] len,
  input wire logic [LEN_W-1:0] lines,
  output logic overlap,
  output logic [1:0] corner
);
  // ----------------------------------------------------------------
  // Extent of one operand
  // ----------------------------------------------------------------
  // First byte past the last sub-block of an operand.
  function automatic logic [ADDR_W-1:0] spanEnd(
    input logic [ADDR_W-1:0] base,
    input logic [PITCH_W-1:0] pitch
  );
    logic [ADDR_W-1:0] rows;
    rows = ADDR_W'(lines) - ADDR_W'(1);
    spanEnd = base + rows * ADDR_W'(pitch) + ADDR_W'(len);
  endfunction

  // Linear intervals are compared, so a pitch larger than the line
  // may report overlap that lies only between lines; the reversed
  // walk is still safe then, only not needed.
  always_comb begin
    overlap = (len != '0) && (lines != '0) &&
              (srcBase < spanEnd(dstBase, dstPitch)) &&
              (dstBase < spanEnd(srcBase, srcPitch));
    // A walk with falling addresses never overtakes its reads when
    // the destination starts above the source in memory.
    corner = (overlap && dstBase > srcBase) ? CORNER_BR
                                            : CORNER_UL;
  end
endmodule
`default_nettype wire

//--- logic/brw_line_addr.sv
`default_nettype none
module brw_line_addr import brw_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] base,
  input wire logic [PITCH_W-1:0] pitch,
  input wire logic [LEN_W-1:0] len,
  input wire logic [LEN_W-1:0] lines,
  input wire logic [1:0] corner,
  input wire logic load,
  input wire logic step,
  output logic [ADDR_W-1:0] addr,
  output logic last
);
  logic [ADDR_W-1:0] lineStart;
  logic [ADDR_W-1:0] firstLine;
  logic [ADDR_W-1:0] nextLine;
  logic [ADDR_W-1:0] xOff;
  logic [LEN_W-1:0] col;
  logic [LEN_W-1:0] row;
  logic colLast;

  // ----------------------------------------------------------------
  // Walk arithmetic
  // ----------------------------------------------------------------
  always_comb begin
    xOff = corner[CORNER_XREV] ? ADDR_W'(len) - ADDR_W'(1) : '0;
    firstLine = base;
    if (corner[CORNER_YREV]) begin
      firstLine = base + (ADDR_W'(lines) - ADDR_W'(1)) *
                  ADDR_W'(pitch);
    end
    nextLine = corner[CORNER_YREV] ? lineStart - ADDR_W'(pitch)
                                   : lineStart + ADDR_W'(pitch);
    colLast = (col == len - LEN_W'(1));
    last = colLast && (row == lines - LEN_W'(1));
  end

  // Address, column and line counters of one operand.
  always_ff @(posedge clk) begin
    if (rst) begin
      lineStart <= '0;
      addr <= '0;
      col <= '0;
      row <= '0;
    end else if (load) begin
      lineStart <= firstLine;
      addr <= firstLine + xOff;
      col <= '0;
      row <= '0;
    end else if (step && colLast) begin
      lineStart <= nextLine;
      addr <= nextLine + xOff;
      col <= '0;
      row <= row + LEN_W'(1);
    end else if (step) begin
      addr <= corner[CORNER_XREV] ? addr - ADDR_W'(1)
                                  : addr + ADDR_W'(1);
      col <= col + LEN_W'(1);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_pitch_step: assert property (step && colLast && !load
    |=> lineStart == $past(nextLine))
    else $error("Line start did not advance by the pitch.");
endmodule
`default_nettype wire

//--- logic/brw_walker.sv
`default_nettype none
module brw_walker import brw_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [REG_DW-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [REG_DW-1:0] regRdata,
  input wire logic [DATA_W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic memRdReq,
  output logic [ADDR_W-1:0] memRdAddr,
  input wire logic [DATA_W-1:0] memRdData,
  input wire logic memRdAck,
  output logic memWrReq,
  output logic [ADDR_W-1:0] memWrAddr,
  output logic [DATA_W-1:0] memWrData,
  input wire logic memWrAck
);
  brw_state_t state;
  logic [ADDR_W-1:0] srcAddr;
  logic [ADDR_W-1:0] dstAddr;
  logic [PITCH_W-1:0] srcPitch;
  logic [PITCH_W-1:0] dstPitch;
  logic [LEN_W-1:0] len;
  logic [LEN_W-1:0] lines;
  logic [REG_DW-1:0] ctrl;
  logic [ADDR_W-1:0] indPtr;
  logic [ADDR_W-1:0] indSize;
  logic goPending;
  logic [1:0] corner;
  logic overlapSeen;
  logic done;
  logic errMono;
  logic errSize;
  logic [DATA_W-1:0] pixel;

  logic busy;
  logic cfgWr;
  logic statusWr;
  logic ctrlCoord;
  logic ctrlStream;
  logic ctrlMono;
  logic ctrlIndirect;
  logic [1:0] ctrlCorner;
  logic srcFromMem;
  logic [ADDR_W-1:0] srcBaseEff;
  logic [PITCH_W-1:0] srcPitchEff;
  logic sizeBad;
  logic monoBad;
  logic overlap;
  logic [1:0] autoCorner;
  logic [1:0] next_corner;
  logic launch;
  logic load;
  logic step;
  logic dstLast;
  logic [ADDR_W-1:0] srcWalkAddr;
  logic [REG_DW-1:0] statusWord;

  // ----------------------------------------------------------------
  // Decode of the command fields
  // ----------------------------------------------------------------
  // Configuration is frozen while a copy runs: the walkers read
  // geometry live, so a write mid-copy would tear the rectangle.
  always_comb begin
    busy = (state != ST_IDLE);
    cfgWr = regWr && !busy && !goPending;
    statusWr = regWr && (regAddr == OFS_STATUS);
    ctrlCoord = ctrl[CTL_COORD];
    ctrlStream = ctrl[CTL_STREAM];
    ctrlMono = ctrl[CTL_MONO];
    ctrlIndirect = ctrl[CTL_INDIRECT];
    ctrlCorner = ctrl[CTL_CORNER_LO +: 2];
    // The indirect packet always reads memory at its pointer.
    srcFromMem = ctrlIndirect || !ctrlStream;
    srcBaseEff = ctrlIndirect ? indPtr : srcAddr;
    // The indirect operand is one contiguous block.
    srcPitchEff = ctrlIndirect ? PITCH_W'(len) : srcPitch;
    sizeBad = ctrlIndirect &&
              (indSize != ADDR_W'(len) * ADDR_W'(lines));
    monoBad = ctrlMono && srcFromMem;
  end

  // ----------------------------------------------------------------
  // Overlap check and starting corner
  // ----------------------------------------------------------------
  brw_overlap u_overlap (
    .srcBase(srcBaseEff),
    .dstBase(dstAddr),
    .srcPitch(srcPitchEff),
    .dstPitch(dstPitch),
    .len(len),
    .lines(lines),
    .overlap(overlap),
    .corner(autoCorner)
  );

  // Coordinate commands pick the corner themselves; the others take
  // the corner from the packet, and the issuer then owns safety.
  always_comb begin
    next_corner = ctrlCoord ? autoCorner : ctrlCorner;
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      srcAddr <= '0;
      dstAddr <= '0;
      srcPitch <= '0;
      dstPitch <= '0;
      len <= '0;
      lines <= '0;
      ctrl <= CTRL_RESET;
      indPtr <= '0;
      indSize <= '0;
    end else if (cfgWr) begin
      unique case (regAddr)
        OFS_SRC_ADDR: srcAddr <= regWdata;
        OFS_DST_ADDR: dstAddr <= regWdata;
        OFS_SRC_PITCH: srcPitch <= regWdata[PITCH_W-1:0];
        OFS_DST_PITCH: dstPitch <= regWdata[PITCH_W-1:0];
        OFS_GEOM: begin
          len <= regWdata[LEN_W-1:0];
          lines <= regWdata[GEOM_LINES_LO +: LEN_W];
        end
        OFS_CTRL: ctrl <= regWdata;
        OFS_IND_PTR: indPtr <= regWdata;
        OFS_IND_SIZE: indSize <= regWdata;
        default: ;
      endcase
    end
  end

  // A start write arms the launch one cycle later, so the decision
  // sees the control word that came with it.
  always_ff @(posedge clk) begin
    if (rst) begin
      goPending <= 1'b0;
    end else begin
      goPending <= cfgWr && (regAddr == OFS_CTRL) &&
                   regWdata[CTL_START];
    end
  end

  // Empty rectangles finish at once without a memory access.
  always_comb begin
    launch = goPending && !monoBad && !sizeBad &&
             (len != '0) && (lines != '0);
    load = (state == ST_LOAD);
    step = (state == ST_WRITE) && memWrAck;
  end

  // ----------------------------------------------------------------
  // Traversal state machine
  // ----------------------------------------------------------------
  // Each pixel is fully read before its write is issued; on coordinate
  // commands the chosen corner keeps every write behind the reads it could hit.
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: if (launch) begin
          state <= ST_LOAD;
        end
        ST_LOAD: state <= ST_FETCH;
        ST_FETCH: begin
          if (srcFromMem ? memRdAck : inValid) begin
            state <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (memWrAck) begin
            state <= dstLast ? ST_IDLE : ST_FETCH;
          end
        end
      endcase
    end
  end

  // Corner used and overlap result, kept for status.
  always_ff @(posedge clk) begin
    if (rst) begin
      corner <= CORNER_UL;
      overlapSeen <= 1'b0;
    end else if (goPending) begin
      corner <= next_corner;
      overlapSeen <= overlap;
    end
  end

  // Pixel holding register between the read and the write.
  always_ff @(posedge clk) begin
    if (rst) begin
      pixel <= '0;
    end else if (state == ST_FETCH && srcFromMem && memRdAck) begin
      pixel <= memRdData;
    end else if (state == ST_FETCH && !srcFromMem && inValid) begin
      pixel <= inData;
    end
  end

  // ----------------------------------------------------------------
  // Source and destination walkers
  // ----------------------------------------------------------------
  // Both walkers share one corner so the two rectangles move in step.
  brw_line_addr u_src_walk (
    .clk(clk),
    .rst(rst),
    .base(srcBaseEff),
    .pitch(srcPitchEff),
    .len(len),
    .lines(lines),
    .corner(corner),
    .load(load),
    .step(step),
    .addr(srcWalkAddr),
    .last()
  );

  brw_line_addr u_dst_walk (
    .clk(clk),
    .rst(rst),
    .base(dstAddr),
    .pitch(dstPitch),
    .len(len),
    .lines(lines),
    .corner(corner),
    .load(load),
    .step(step),
    .addr(memWrAddr),
    .last(dstLast)
  );

  // ----------------------------------------------------------------
  // Memory and stream handshakes
  // ----------------------------------------------------------------
  // Inline data is taken only while a stream-sourced pixel is due,
  // which holds back the words that follow the command.
  always_comb begin
    inReady = (state == ST_FETCH) && !srcFromMem;
    memRdReq = (state == ST_FETCH) && srcFromMem;
    memRdAddr = srcWalkAddr;
    memWrReq = (state == ST_WRITE);
    memWrData = pixel;
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Flags clear by writing ones; a set in the same cycle wins.
  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
      errMono <= 1'b0;
      errSize <= 1'b0;
    end else begin
      if (step && dstLast) begin
        done <= 1'b1;
      end else if (goPending && launch == 1'b0 && !monoBad &&
                   !sizeBad) begin
        done <= 1'b1;
      end else if (statusWr && regWdata[ST_DONE]) begin
        done <= 1'b0;
      end
      if (goPending && monoBad) begin
        errMono <= 1'b1;
      end else if (statusWr && regWdata[ST_ERR_MONO]) begin
        errMono <= 1'b0;
      end
      if (goPending && sizeBad) begin
        errSize <= 1'b1;
      end else if (statusWr && regWdata[ST_ERR_SIZE]) begin
        errSize <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    statusWord = '0;
    statusWord[ST_BUSY] = busy || goPending;
    statusWord[ST_CORNER_LO +: 2] = corner;
    statusWord[ST_OVERLAP] = overlapSeen;
    statusWord[ST_DONE] = done;
    statusWord[ST_ERR_MONO] = errMono;
    statusWord[ST_ERR_SIZE] = errSize;
  end

  // Data stands only in the cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (rst || !regRd) begin
      regRdata <= '0;
    end else begin
      unique case (regAddr)
        OFS_SRC_ADDR: regRdata <= srcAddr;
        OFS_DST_ADDR: regRdata <= dstAddr;
        OFS_SRC_PITCH: regRdata <= REG_DW'(srcPitch);
        OFS_DST_PITCH: regRdata <= REG_DW'(dstPitch);
        OFS_GEOM: regRdata <= {lines, len};
        OFS_CTRL: regRdata <= ctrl;
        OFS_IND_PTR: regRdata <= indPtr;
        OFS_IND_SIZE: regRdata <= indSize;
        OFS_STATUS: regRdata <= statusWord;
        default: regRdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence sLaunchFwd;
    (state == ST_LOAD) && (corner == CORNER_UL) && srcFromMem;
  endsequence

  sequence sPixelRead;
    (state == ST_FETCH) ##1 (state == ST_WRITE);
  endsequence

  a_auto_corner: assert property (goPending && ctrlCoord
    |=> corner == $past(autoCorner))
    else $error("Coordinate command took the wrong corner.");

  a_read_first: assert property ($rose(memWrReq)
    |-> $past(state) == ST_FETCH)
    else $error("Write issued before its pixel was read.");

  a_read_write: assert property (sPixelRead |-> memWrReq &&
    memWrData == $past(srcFromMem ? memRdData : inData))
    else $error("Fetched pixel was not written.");

  a_start_origin: assert property (sLaunchFwd
    |=> memRdReq && memRdAddr == $past(srcBaseEff))
    else $error("Forward walk did not start at the base.");

  a_manual_corner: assert property (goPending && !ctrlCoord
    |=> corner == $past(ctrlCorner))
    else $error("Packet corner was not honoured.");

  a_reverse_corner: assert property (goPending && ctrlCoord &&
    overlap && dstAddr > srcBaseEff |=> corner == CORNER_BR)
    else $error("Overlap did not reverse the walk.");

  a_mono_refused: assert property (goPending && monoBad
    |=> errMono && state == ST_IDLE)
    else $error("Monochrome memory source was accepted.");

  a_stream_take: assert property (inReady
    |-> !memRdReq && ctrlStream && !ctrlIndirect)
    else $error("Inline data taken outside a stream copy.");

  a_size_refused: assert property (goPending && sizeBad
    |=> errSize && state == ST_IDLE)
    else $error("Indirect size mismatch was accepted.");

  a_default_corner: assert property (goPending && ctrlCoord &&
    !overlap |=> corner == CORNER_UL)
    else $error("No overlap but corner not upper left.");

  a_copy_done: assert property (step && dstLast
    |=> state == ST_IDLE && done)
    else $error("Copy did not end after the last sub-block.");
endmodule
`default_nettype wire

//--- tb/brw_mem_model.sv
`default_nettype none
module brw_mem_model import brw_pkg::*; (
  input wire logic clk,
  input wire logic slow,
  input wire logic memRdReq,
  input wire logic [ADDR_W-1:0] memRdAddr,
  output logic [DATA_W-1:0] memRdData,
  output logic memRdAck,
  input wire logic memWrReq,
  input wire logic [ADDR_W-1:0] memWrAddr,
  input wire logic [DATA_W-1:0] memWrData,
  output logic memWrAck
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // Sparse byte store
  // ----
  logic [DATA_W-1:0] mem [int unsigned];
  int rdWait = 0;
  int wrWait = 0;

  // Untouched bytes read a fixed address hash, so stale data shows.
  function automatic logic [DATA_W-1:0] peek(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8] ^ 8'h5a);
  endfunction

  initial begin
    memRdAck = 1'b0;
    memWrAck = 1'b0;
    memRdData = 8'h00;
  end

  // Read port; idle data churns so a late sample is never right by luck.
  always @(posedge clk) begin
    if (memRdReq && !memRdAck && rdWait == 0) begin
      memRdAck <= 1'b1;
      memRdData <= peek(memRdAddr);
      rdWait <= slow ? $urandom_range(3) : 0;
    end else begin
      memRdAck <= 1'b0;
      memRdData <= memRdData + 8'h3b;
      if (memRdReq && !memRdAck) rdWait <= rdWait - 1;
    end
  end

  // Write port; bytes land in issue order, so an early overwrite sticks.
  always @(posedge clk) begin
    if (memWrReq && !memWrAck && wrWait == 0) begin
      memWrAck <= 1'b1;
      mem[memWrAddr] = memWrData;
      wrWait <= slow ? $urandom_range(3) : 0;
    end else begin
      memWrAck <= 1'b0;
      if (memWrReq && !memWrAck) wrWait <= wrWait - 1;
    end
  end
endmodule
`default_nettype wire

//--- tb/brw_walker_tb.sv
`default_nettype none
module brw_walker_tb import brw_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, regWr = 0, regRd = 0, inValid = 0, slow = 0;
  logic [REG_AW-1:0] regAddr = 4'h0;
  logic [REG_DW-1:0] regWdata = 32'h0, regRdata;
  logic [DATA_W-1:0] inData = 8'h00, memRdData, memWrData;
  logic inReady, memRdReq, memRdAck, memWrReq, memWrAck;
  logic [ADDR_W-1:0] memRdAddr, memWrAddr, firstRd;
  int fail_count = 0, tests_run = 0, wrCnt = 0, idx = 0, seen = 0;

  brw_walker u_dut (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .inData, .inValid, .inReady, .memRdReq, .memRdAddr,
    .memRdData, .memRdAck, .memWrReq, .memWrAddr, .memWrData, .memWrAck);
  brw_mem_model u_mem (.clk, .slow, .memRdReq, .memRdAddr, .memRdData,
    .memRdAck, .memWrReq, .memWrAddr, .memWrData, .memWrAck);

  // 10 MHz clock.
  initial forever #50 clk = ~clk;

  // ----
  // Monitors and inline source
  // ----
  function automatic logic [7:0] sb(input int i);
    return 8'(i * 7 + 1);
  endfunction

  // Inline bytes advance only on an accepted handshake.
  always @(posedge clk) begin
    if (memRdReq && seen == 0) begin
      firstRd = memRdAddr;
      seen = 1;
    end
    if (memWrReq && memWrAck) wrCnt++;
    if (inReady && inValid) begin
      idx++;
      inData <= sb(idx);
    end
  end

  // ----
  // Bus tasks and checks
  // ----
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic end_of_test;
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask

  // Linear spans are compared, so a reversal may be merely cautious.
  function automatic logic ovl(input logic [31:0] s, d, input int sp,
                               dp, l, n);
    return s < d + (n - 1) * dp + l && d < s + (n - 1) * sp + l;
  endfunction

  // One full copy: program, launch, wait, then judge flags and memory.
  task automatic copy(input logic [31:0] s, d, input int sp, dp, l, n,
                      input logic [6:0] ctl, input int z);
    logic [7:0] exp[$];
    logic [31:0] st;
    logic [1:0] c;
    logic ov, em, es, bad;
    int k;
    ov = ovl(s, d, sp, dp, l, n);
    c = ctl[1] ? ((ov && d > s) ? CORNER_BR : CORNER_UL) : ctl[3:2];
    em = ctl[5] && (!ctl[4] || ctl[6]);
    es = ctl[6] && z != l * n;
    bad = em || es;
    for (int y = 0; y < n; y++)
      for (int x = 0; x < l; x++)
        exp.push_back(ctl[4] ? sb(y * l + x) : u_mem.peek(s + y * sp + x));
    wr(OFS_SRC_ADDR, s);
    wr(OFS_DST_ADDR, d);
    wr(OFS_SRC_PITCH, sp);
    wr(OFS_DST_PITCH, dp);
    wr(OFS_GEOM, {n[15:0], l[15:0]});
    wr(OFS_IND_PTR, s);
    wr(OFS_IND_SIZE, z);
    seen = 0;
    wrCnt = 0;
    idx = 0;
    inData <= sb(0);
    inValid <= ctl[4];
    wr(OFS_CTRL, {25'h0, ctl});
    k = 0;
    do begin
      rd(OFS_STATUS, st);
      k++;
    end while (st[ST_BUSY] !== 1'b0 && k < 3000);
    inValid <= 1'b0;
    chk("busy", 0, st[ST_BUSY]);
    if (st[ST_BUSY] !== 1'b0) end_of_test;
    chk("done", !bad, st[ST_DONE]);
    chk("errMono", em, st[ST_ERR_MONO]);
    chk("errSize", es, st[ST_ERR_SIZE]);
    chk("corner", c, st[2:1]);
    if (ctl[1]) chk("overlap", ov, st[ST_OVERLAP]);
    chk("writes", bad ? 0 : l * n, wrCnt);
    if (!bad && !ctl[4] && l * n != 0)
      chk("firstRd", s + (c[1] ? (n - 1) * sp : 0) + (c[0] ? l - 1 : 0),
          firstRd);
    for (int y = 0; y < n && !bad; y++)
      for (int x = 0; x < l; x++)
        chk("data", exp[y * l + x], u_mem.peek(d + y * dp + x));
    wr(OFS_STATUS, 32'h70);
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    int l, n, p;
    logic [31:0] v, s;
    void'($urandom(32'ha6a6365f));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_STATUS, v);
    chk("statusRst", 0, v);
    rd(OFS_CTRL, v);
    chk("ctrlRst", CTRL_RESET, v);
    rd(4'hf, v);
    chk("unmapped", 0, v);
    wr(OFS_DST_PITCH, 32'h1234);
    rd(OFS_DST_PITCH, v);
    chk("pitch", 32'h1234, v);
    for (int c = 0; c < 4; c++)
      copy(32'h1000, 32'h8000, 40, 64, 5, 3, 7'(1 + 4 * c), 0);
    copy(32'h2000, 32'h2042, 32, 32, 6, 4, 7'h03, 0);
    copy(32'h2142, 32'h2100, 32, 32, 6, 4, 7'h03, 0);
    copy(32'h3000, 32'h6000, 16, 16, 4, 2, 7'h03, 0);
    copy(32'h1000, 32'h8000, 40, 64, 0, 3, 7'h01, 0);
    copy(32'h0, 32'h5000, 0, 8, 8, 3, 7'h11, 0);
    copy(32'h0, 32'h5100, 0, 8, 8, 1, 7'h31, 0);
    copy(32'h4000, 32'h5200, 8, 8, 8, 2, 7'h21, 0);
    copy(32'h4000, 32'h5300, 4, 8, 4, 2, 7'h41, 8);
    copy(32'h4000, 32'h5400, 4, 8, 4, 2, 7'h41, 9);
    repeat (24) begin
      slow = 1'($urandom_range(1));
      l = 1 + $urandom_range(7);
      n = 1 + $urandom_range(5);
      p = l + $urandom_range(8);
      s = 32'h7000 + $urandom_range(255);
      copy(s, s + $urandom_range(128) - 64, p, p, l, n, 7'h03, 0);
    end
    end_of_test;
  end
endmodule
`default_nettype wire
